// ==== hdl/trc_reference_config.sv ====
// Touch converter reference, settle and panel timing configuration
`default_nettype none
`include "trc_params.svh"
module trc_reference_config #(
  parameter int unsigned CLK_PERIOD_NS = `TRC_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Serial host port
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  output logic miso,
  output logic misoOe,
  // Conversion sequencer
  input wire logic convRequest,
  input wire logic convActive,
  output logic convGo,
  output logic settleBusy,
  input wire logic prechargeStart,
  output logic prechargeDone,
  input wire logic senseStart,
  output logic senseDone,
  // Reference control
  output logic refPowerOn,
  output logic refInternal,
  output logic refLevelHigh
);
  trc_pkg::trc_core_s state_reg;
  trc_pkg::trc_core_s state_next;
  logic cmdDone;
  logic wrStrobe;
  logic [15:0] cmdWord;
  logic [15:0] wrData;
  logic [15:0] rdData;
  logic [5:0] addr;
  logic pageHit;
  logic needSettle;
  logic settleStart;
  logic settleDone;
  logic settleTimerBusy;
  trc_pkg::trc_cycles_t settleCycles;
  trc_pkg::trc_cycles_t prechargeCycles;
  trc_pkg::trc_cycles_t senseCycles;
  logic [1:0] delayCode;
  logic [2:0] prechargeCode;
  logic [2:0] senseCode;

  // Least time rounded up to whole cycles, never below one
  function automatic trc_pkg::trc_cycles_t toCycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c == 0) begin
      c = 1;
    end
    return trc_pkg::trc_cycles_t'(c);
  endfunction : toCycles

  trc_serial_port port (
    .clock(clock),
    .rstn(rstn),
    .sclk(sclk),
    .csN(csN),
    .mosi(mosi),
    .miso(miso),
    .misoOe(misoOe),
    .cmdDone(cmdDone),
    .wrStrobe(wrStrobe),
    .cmdWord(cmdWord),
    .wrData(wrData),
    .rdData(rdData)
  );

  assign addr = cmdWord[`TRC_CMD_ADDR_MSB:`TRC_CMD_ADDR_LSB];
  assign pageHit = cmdWord[`TRC_CMD_PAGE_MSB:`TRC_CMD_PAGE_LSB] == `TRC_PAGE;
  assign delayCode = state_reg.refSetup[`TRC_REF_DELAY_MSB:`TRC_REF_DELAY_LSB];
  assign prechargeCode =
    state_reg.panelSetup[`TRC_PRECHARGE_MSB:`TRC_PRECHARGE_LSB];
  assign senseCode = state_reg.panelSetup[`TRC_SENSE_MSB:`TRC_SENSE_LSB];

  // Read data, unused bits read as zero, reserved register reads as all ones
  always_comb begin
    rdData = `TRC_UNMAPPED_VALUE;
    if (!pageHit) begin
      rdData = `TRC_UNMAPPED_VALUE;
    end else if (addr == `TRC_OFS_RESERVED) begin
      rdData = `TRC_RESERVED_VALUE;
    end else if (addr == `TRC_OFS_REFERENCE) begin
      rdData = {11'h000, state_reg.refSetup};
    end else if (addr == `TRC_OFS_SOFT_RESET) begin
      rdData = state_reg.softReset;
    end else if (addr == `TRC_OFS_PANEL) begin
      rdData = {10'h000, state_reg.panelSetup};
    end
  end

  always_comb begin
    case (delayCode)
      2'b00: settleCycles = toCycles(`TRC_SETTLE_0_NS);
      2'b01: settleCycles = toCycles(`TRC_SETTLE_1_NS);
      2'b10: settleCycles = toCycles(`TRC_SETTLE_2_NS);
      default: settleCycles = toCycles(`TRC_SETTLE_3_NS);
    endcase
    case (prechargeCode)
      3'b000: prechargeCycles = toCycles(`TRC_PRE_0_NS);
      3'b001: prechargeCycles = toCycles(`TRC_PRE_1_NS);
      3'b010: prechargeCycles = toCycles(`TRC_PRE_2_NS);
      3'b011: prechargeCycles = toCycles(`TRC_PRE_3_NS);
      3'b100: prechargeCycles = toCycles(`TRC_PRE_4_NS);
      3'b101: prechargeCycles = toCycles(`TRC_PRE_5_NS);
      3'b110: prechargeCycles = toCycles(`TRC_PRE_6_NS);
      default: prechargeCycles = toCycles(`TRC_PRE_7_NS);
    endcase
    case (senseCode)
      3'b000: senseCycles = toCycles(`TRC_SENSE_0_NS);
      3'b001: senseCycles = toCycles(`TRC_SENSE_1_NS);
      3'b010: senseCycles = toCycles(`TRC_SENSE_2_NS);
      3'b011: senseCycles = toCycles(`TRC_SENSE_3_NS);
      3'b100: senseCycles = toCycles(`TRC_SENSE_4_NS);
      3'b101: senseCycles = toCycles(`TRC_SENSE_5_NS);
      3'b110: senseCycles = toCycles(`TRC_SENSE_6_NS);
      default: senseCycles = toCycles(`TRC_SENSE_7_NS);
    endcase
  end

  // Settle wait applies only to a sleeping internal reference
  assign needSettle = state_reg.refSetup[`TRC_REF_SOURCE_BIT]
                    & state_reg.refSetup[`TRC_REF_SLEEP_BIT]
                    & (delayCode != 2'b00);
  assign settleStart = convRequest && state_reg.settle == trc_pkg::TRC_IDLE
                       && needSettle;

  always_comb begin
    state_next = state_reg;
    state_next.convGo = 1'b0;
    case (state_reg.settle)
      trc_pkg::TRC_IDLE: begin
        if (convRequest) begin
          if (needSettle) begin
            state_next.settle = trc_pkg::TRC_SETTLE;
          end else begin
            state_next.convGo = 1'b1;
          end
        end
      end
      trc_pkg::TRC_SETTLE: begin
        if (settleDone) begin
          state_next.settle = trc_pkg::TRC_IDLE;
          state_next.convGo = 1'b1;
        end
      end
      default: begin
        state_next.settle = trc_pkg::TRC_IDLE;
      end
    endcase
    if (wrStrobe && pageHit) begin
      if (addr == `TRC_OFS_REFERENCE) begin
        state_next.refSetup = wrData[4:0];
      end else if (addr == `TRC_OFS_SOFT_RESET) begin
        // Only the documented code has a defined effect
        if (wrData == `TRC_RESET_EVERYTHING_CODE) begin
          state_next.refSetup = `TRC_REF_DEFAULT;
          state_next.panelSetup = `TRC_PANEL_DEFAULT;
          state_next.softReset = `TRC_SOFT_RESET_DEFAULT;
        end else begin
          state_next.softReset = wrData;
        end
      end else if (addr == `TRC_OFS_PANEL) begin
        state_next.panelSetup = wrData[5:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= '{refSetup: `TRC_REF_DEFAULT,
                     panelSetup: `TRC_PANEL_DEFAULT,
                     softReset: `TRC_SOFT_RESET_DEFAULT,
                     settle: trc_pkg::TRC_IDLE, convGo: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  trc_interval_timer settleTimer (
    .clock(clock),
    .rstn(rstn),
    .start(settleStart),
    .cycles(settleCycles),
    .busy(settleTimerBusy),
    .done(settleDone)
  );

  trc_interval_timer prechargeTimer (
    .clock(clock),
    .rstn(rstn),
    .start(prechargeStart),
    .cycles(prechargeCycles),
    .busy(),
    .done(prechargeDone)
  );

  trc_interval_timer senseTimer (
    .clock(clock),
    .rstn(rstn),
    .start(senseStart),
    .cycles(senseCycles),
    .busy(),
    .done(senseDone)
  );

  assign convGo = state_reg.convGo;
  assign settleBusy = state_reg.settle == trc_pkg::TRC_SETTLE;
  assign refInternal = state_reg.refSetup[`TRC_REF_SOURCE_BIT];
  assign refLevelHigh = state_reg.refSetup[`TRC_REF_LEVEL_BIT];
  // Powered when internal and either always-on or in use
  assign refPowerOn = refInternal
                    & (~state_reg.refSetup[`TRC_REF_SLEEP_BIT]
                       | convActive | settleTimerBusy
                       | settleBusy);
endmodule : trc_reference_config
`default_nettype wire

// ==== hdl/trc_params.svh ====
// Offsets, field positions, reset values and timing figures of the block
`ifndef TRC_PARAMS_SVH
`define TRC_PARAMS_SVH

`define TRC_CLK_PERIOD_NS 50
`define TRC_PAGE 4'h1
`define TRC_OFS_RESERVED 6'h02
`define TRC_OFS_REFERENCE 6'h03
`define TRC_OFS_SOFT_RESET 6'h04
`define TRC_OFS_PANEL 6'h05
`define TRC_RESERVED_VALUE 16'hffff
`define TRC_SOFT_RESET_DEFAULT 16'hffff
`define TRC_RESET_EVERYTHING_CODE 16'hbb00
`define TRC_REF_DEFAULT 5'h02
`define TRC_PANEL_DEFAULT 6'h00
`define TRC_UNMAPPED_VALUE 16'h0000
// Serial command word layout
`define TRC_CMD_READ_BIT 15
`define TRC_CMD_PAGE_MSB 14
`define TRC_CMD_PAGE_LSB 11
`define TRC_CMD_ADDR_MSB 10
`define TRC_CMD_ADDR_LSB 5
`define TRC_CMD_LAST_BIT 6'd15
`define TRC_DATA_LAST_BIT 6'd31
`define TRC_FRAME_BITS 6'd32
// Reference setup fields
`define TRC_REF_SOURCE_BIT 4
`define TRC_REF_DELAY_MSB 3
`define TRC_REF_DELAY_LSB 2
`define TRC_REF_SLEEP_BIT 1
`define TRC_REF_LEVEL_BIT 0
// Panel timing fields
`define TRC_PRECHARGE_MSB 5
`define TRC_PRECHARGE_LSB 3
`define TRC_SENSE_MSB 2
`define TRC_SENSE_LSB 0
// Durations in ns
`define TRC_SETTLE_0_NS 0
`define TRC_SETTLE_1_NS 100000
`define TRC_SETTLE_2_NS 500000
`define TRC_SETTLE_3_NS 1000000
`define TRC_PRE_0_NS 20000
`define TRC_PRE_1_NS 84000
`define TRC_PRE_2_NS 276000
`define TRC_PRE_3_NS 340000
`define TRC_PRE_4_NS 1044000
`define TRC_PRE_5_NS 1108000
`define TRC_PRE_6_NS 1300000
`define TRC_PRE_7_NS 1364000
`define TRC_SENSE_0_NS 32000
`define TRC_SENSE_1_NS 96000
`define TRC_SENSE_2_NS 544000
`define TRC_SENSE_3_NS 608000
`define TRC_SENSE_4_NS 2080000
`define TRC_SENSE_5_NS 2144000
`define TRC_SENSE_6_NS 2592000
`define TRC_SENSE_7_NS 2656000

`endif

// ==== hdl/trc_pkg.sv ====
// Types shared by the reference and timing configuration block
`default_nettype none
package trc_pkg;
  typedef logic [16:0] trc_cycles_t;

  typedef enum logic [1:0] {
    TRC_IDLE = 2'b01,
    TRC_SETTLE = 2'b10
  } trc_settle_e;

  typedef struct packed {
    logic [2:0] sclkSync;
    logic [2:0] csSync;
    logic [2:0] mosiSync;
    logic sclkStable;
    logic csNStable;
    logic [5:0] bitCnt;
    logic [15:0] inShift;
    logic [15:0] cmdWord;
    logic [15:0] outShift;
    logic cmdDone;
    logic wrStrobe;
    logic miso;
  } trc_serial_s;

  typedef struct packed {
    trc_cycles_t count;
    logic busy;
    logic done;
  } trc_timer_s;

  typedef struct packed {
    logic [4:0] refSetup;
    logic [5:0] panelSetup;
    logic [15:0] softReset;
    trc_settle_e settle;
    logic convGo;
  } trc_core_s;
endpackage : trc_pkg
`default_nettype wire

// ==== hdl/trc_serial_port.sv ====
// Serial host port: 16-bit command word then 16-bit data word
`default_nettype none
`include "trc_params.svh"
module trc_serial_port (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Serial pins
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  output logic miso,
  output logic misoOe,
  // Register side
  output logic cmdDone,
  output logic wrStrobe,
  output logic [15:0] cmdWord,
  output logic [15:0] wrData,
  input wire logic [15:0] rdData
);
  trc_pkg::trc_serial_s state_reg;
  trc_pkg::trc_serial_s state_next;
  logic rise;
  logic fall;
  logic isRead;

  always_comb begin
    state_next = state_reg;
    state_next.cmdDone = 1'b0;
    state_next.wrStrobe = 1'b0;
    state_next.sclkSync = {state_reg.sclkSync[1:0], sclk};
    state_next.csSync = {state_reg.csSync[1:0], csN};
    state_next.mosiSync = {state_reg.mosiSync[1:0], mosi};
    // A level counts only once the second and third stages agree
    if (state_reg.sclkSync[1] == state_reg.sclkSync[2]) begin
      state_next.sclkStable = state_reg.sclkSync[2];
    end
    if (state_reg.csSync[1] == state_reg.csSync[2]) begin
      state_next.csNStable = state_reg.csSync[2];
    end
    rise = state_next.sclkStable & ~state_reg.sclkStable;
    fall = ~state_next.sclkStable & state_reg.sclkStable;
    isRead = state_reg.cmdWord[`TRC_CMD_READ_BIT];
    if (state_reg.csNStable) begin
      state_next.bitCnt = 6'h00;
      state_next.miso = 1'b0;
    end else begin
      if (rise && state_reg.bitCnt < `TRC_FRAME_BITS) begin
        state_next.inShift = {state_reg.inShift[14:0],
                              state_reg.mosiSync[2]};
        state_next.bitCnt = state_reg.bitCnt + 6'h01;
        if (state_reg.bitCnt == `TRC_CMD_LAST_BIT) begin
          state_next.cmdWord = state_next.inShift;
          state_next.cmdDone = 1'b1;
        end
        if (state_reg.bitCnt == `TRC_DATA_LAST_BIT && !isRead) begin
          state_next.wrStrobe = 1'b1;
        end
      end
      // Read data is loaded the cycle after the command completes
      if (state_reg.cmdDone && isRead) begin
        state_next.outShift = rdData;
        state_next.miso = rdData[15];
      end else if (fall && isRead && state_reg.bitCnt > 6'd16) begin
        state_next.outShift = {state_reg.outShift[14:0], 1'b0};
        state_next.miso = state_reg.outShift[14];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= '{sclkSync: 3'h0, csSync: 3'h7, mosiSync: 3'h0,
                     sclkStable: 1'b0, csNStable: 1'b1, bitCnt: 6'h00,
                     inShift: 16'h0000, cmdWord: 16'h0000,
                     outShift: 16'h0000, cmdDone: 1'b0, wrStrobe: 1'b0,
                     miso: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign miso = state_reg.miso;
  assign misoOe = ~state_reg.csNStable;
  assign cmdDone = state_reg.cmdDone;
  assign wrStrobe = state_reg.wrStrobe;
  assign cmdWord = state_reg.cmdWord;
  assign wrData = state_reg.inShift;
endmodule : trc_serial_port
`default_nettype wire

// ==== hdl/trc_interval_timer.sv ====
// One-shot countdown: done pulses a given number of cycles after start
`default_nettype none
module trc_interval_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Control
  input wire logic start,
  input wire trc_pkg::trc_cycles_t cycles,
  // Status
  output logic busy,
  output logic done
);
  trc_pkg::trc_timer_s state_reg;
  trc_pkg::trc_timer_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    if (start) begin
      state_next.count = cycles;
      state_next.busy = 1'b1;
    end else if (state_reg.busy) begin
      if (state_reg.count <= 17'd1) begin
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
        state_next.count = 17'd0;
      end else begin
        state_next.count = state_reg.count - 17'd1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= '{count: 17'd0, busy: 1'b0, done: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = state_reg.busy;
  assign done = state_reg.done;
endmodule : trc_interval_timer
`default_nettype wire

// ==== sim/trc_ref_props.sv ====
// Port assertions for the reference and timing configuration block
`default_nettype none
module trc_ref_props #(
  parameter int unsigned CLK_PERIOD_NS = 50
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Serial select
  input wire logic misoOe,
  // Sequencer
  input wire logic convRequest,
  input wire logic convActive,
  input wire logic convGo,
  input wire logic settleBusy,
  input wire logic prechargeStart,
  input wire logic prechargeDone,
  input wire logic senseStart,
  input wire logic senseDone,
  // Reference
  input wire logic refPowerOn,
  input wire logic refInternal,
  input wire logic refLevelHigh
);
  localparam int unsigned MaxSettle = 1000000 / CLK_PERIOD_NS + 3;
  logic [31:0] busyCnt_reg;

  always_ff @(posedge clock) begin
    if (!rstn || !settleBusy) busyCnt_reg <= 32'h00000000;
    else busyCnt_reg <= busyCnt_reg + 32'h00000001;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_ext_ref_off: assert property (!refInternal |-> !refPowerOn)
    else $error("internal reference powered in external mode");
  chk_active_powered: assert property (
    convActive && refInternal |-> refPowerOn)
    else $error("reference off during conversion");
  chk_settle_needs_ref: assert property (
    settleBusy |-> refPowerOn && refInternal)
    else $error("settling without powered internal reference");
  chk_settle_min: assert property (
    $rose(settleBusy) |-> settleBusy[*8])
    else $error("settle wait too short");
  chk_settle_max: assert property (busyCnt_reg <= MaxSettle)
    else $error("settle wait too long");
  chk_go_cause: assert property (convGo |-> $past(convRequest)
    || $past(convRequest, 2) || $past(settleBusy))
    else $error("measurement start without request");
  chk_go_single: assert property (convGo |=> !convGo)
    else $error("measurement start longer than one cycle");
  chk_pre_min: assert property (prechargeStart |=> !prechargeDone[*3])
    else $error("precharge ended too early");
  chk_sense_min: assert property (senseStart |=> !senseDone[*6])
    else $error("sense ended too early");
  chk_level_by_write: assert property (
    $changed(refLevelHigh) |-> misoOe || $past(misoOe))
    else $error("level changed outside a frame");
  chk_source_by_write: assert property (
    $changed(refInternal) |-> misoOe || $past(misoOe))
    else $error("source changed outside a frame");

  cover property ($fell(settleBusy));
  cover property (prechargeDone);
  cover property (senseDone);
endmodule : trc_ref_props

bind trc_reference_config trc_ref_props #(.CLK_PERIOD_NS(CLK_PERIOD_NS)) u_props (
  .clock(clock), .rstn(rstn), .misoOe(misoOe), .convRequest(convRequest),
  .convActive(convActive), .convGo(convGo), .settleBusy(settleBusy),
  .prechargeStart(prechargeStart), .prechargeDone(prechargeDone),
  .senseStart(senseStart), .senseDone(senseDone), .refPowerOn(refPowerOn),
  .refInternal(refInternal), .refLevelHigh(refLevelHigh)
);
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the reference and timing configuration block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Slow clock period shrinks every count
  localparam int unsigned Per = 5000;
  logic clock, rstn, sclk, csN, mosi, miso, misoOe;
  logic convRequest, convActive, convGo, settleBusy;
  logic prechargeStart, prechargeDone, senseStart, senseDone;
  logic refPowerOn, refInternal, refLevelHigh;
  logic [2:0] pins;
  int errors, checksDone;
  int unsigned setl[4] = '{0, 20, 100, 200};
  int unsigned pre[8] = '{4, 17, 56, 68, 209, 222, 260, 273};
  int unsigned sen[8] = '{7, 20, 109, 122, 416, 429, 519, 532};

  trc_reference_config #(.CLK_PERIOD_NS(Per)) dut (
    .clock(clock), .rstn(rstn), .sclk(sclk), .csN(csN), .mosi(mosi),
    .miso(miso), .misoOe(misoOe), .convRequest(convRequest),
    .convActive(convActive), .convGo(convGo), .settleBusy(settleBusy),
    .prechargeStart(prechargeStart), .prechargeDone(prechargeDone),
    .senseStart(senseStart), .senseDone(senseDone),
    .refPowerOn(refPowerOn), .refInternal(refInternal),
    .refLevelHigh(refLevelHigh)
  );

  assign pins = {refInternal, refLevelHigh, refPowerOn};

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic closeOut;
    if (errors == 0 && checksDone > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : closeOut

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // One frame, mode 0: data set while sclk low, read bits taken at rises
  task automatic xfer(input logic rd, input logic [5:0] adr,
                      input logic [15:0] dat, output logic [15:0] q);
    logic [31:0] w;
    w = {rd, 4'h1, adr, 5'h00, dat};
    q = 16'h0000;
    @(posedge clock);
    csN <= 1'b0;
    tick(8);
    check({15'h0000, misoOe}, 16'h0001, "output enable while selected");
    for (int i = 0; i < 32; i++) begin
      mosi <= w[31 - i];
      tick(8);
      if (i >= 16) q[31 - i] = miso;
      sclk <= 1'b1;
      tick(8);
      sclk <= 1'b0;
    end
    tick(8);
    csN <= 1'b1;
    tick(8);
  endtask : xfer

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(1'b0, a, d, q);
  endtask : wr

  task automatic rdchk(input logic [5:0] a, input logic [15:0] e,
                       input string s);
    logic [15:0] q;
    xfer(1'b1, a, 16'h0000, q);
    check(q, e, s);
  endtask : rdchk

  // Pulses a start, counts edges until its answer; sel 0 conv, 1 pre, 2 sense
  task automatic pulse(input int sel, output int k, output logic b);
    logic d;
    k = 0;
    d = 1'b0;
    b = 1'b0;
    @(posedge clock);
    if (sel == 0) convRequest <= 1'b1;
    else if (sel == 1) prechargeStart <= 1'b1;
    else senseStart <= 1'b1;
    while (d !== 1'b1 && k < 2000) begin
      @(posedge clock);
      k++;
      convRequest <= 1'b0;
      prechargeStart <= 1'b0;
      senseStart <= 1'b0;
      #1;
      d = sel == 0 ? convGo : (sel == 1 ? prechargeDone : senseDone);
      if (k == 2) b = settleBusy;
    end
    if (d !== 1'b1) begin
      errors++;
      closeOut();
    end
  endtask : pulse

  task automatic s_defaults;
    rdchk(6'h03, 16'h0002, "reference default");
    rdchk(6'h04, 16'hffff, "reset register default");
    rdchk(6'h05, 16'h0000, "panel default");
    wr(6'h02, 16'h1234);
    rdchk(6'h02, 16'hffff, "reserved register");
    rdchk(6'h06, 16'h0000, "unmapped register");
    check({15'h0000, misoOe}, 16'h0000, "output enable while idle");
    check({15'h0000, refPowerOn}, 16'h0000, "external ref off");
  endtask : s_defaults

  task automatic s_ref;
    wr(6'h03, 16'hfff1);
    check(16'(pins), 16'h0007, "on");
    rdchk(6'h03, 16'h0011, "reference readback");
    wr(6'h03, 16'h0001);
    check(16'(pins), 16'h0002, "ext");
    wr(6'h03, 16'h0012);
    check(16'(pins), 16'h0004, "nap");
    convActive <= 1'b1;
    tick(2);
    check({15'h0000, refPowerOn}, 16'h0001, "on while converting");
    convActive <= 1'b0;
  endtask : s_ref

  task automatic s_settle;
    int k;
    logic b;
    for (int c = 0; c < 4; c++) begin
      wr(6'h03, {11'h000, 1'b1, c[1:0], 2'b10});
      pulse(0, k, b);
      check(16'(k), c == 0 ? 16'h0001 : 16'(setl[c] + 2), "settle");
      if (c != 0) check({15'h0000, b}, 16'h0001, "settle busy");
    end
    wr(6'h03, 16'h000e);
    pulse(0, k, b);
    check(16'(k), 16'h0001, "no settle external");
    wr(6'h03, 16'h001c);
    pulse(0, k, b);
    check(16'(k), 16'h0001, "no settle always on");
  endtask : s_settle

  task automatic s_timers;
    int k;
    logic b;
    for (int c = 0; c < 8; c++) begin
      wr(6'h05, {10'h000, c[2:0], c[2:0]});
      pulse(1, k, b);
      check(16'(k), 16'(pre[c] + 1), "precharge time");
      pulse(2, k, b);
      check(16'(k), 16'(sen[c] + 1), "sense time");
    end
  endtask : s_timers

  task automatic s_soft;
    wr(6'h03, 16'h0013);
    wr(6'h05, 16'h003f);
    wr(6'h04, 16'hbb00);
    rdchk(6'h03, 16'h0002, "reference restored");
    rdchk(6'h05, 16'h0000, "panel restored");
    rdchk(6'h04, 16'hffff, "reset register restored");
    check({14'h0000, refInternal, refLevelHigh}, 16'h0000, "pins");
  endtask : s_soft

  initial begin
    errors = 0;
    checksDone = 0;
    rstn = 1'b0;
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
    convRequest = 1'b0;
    convActive = 1'b0;
    prechargeStart = 1'b0;
    senseStart = 1'b0;
    tick(8);
    rstn <= 1'b1;
    tick(4);
    s_defaults();
    s_ref();
    s_settle();
    s_timers();
    s_soft();
    closeOut();
  end
endmodule : tb
`default_nettype wire
